// ### inc/apd_pkg.sv
package apd_pkg;
  localparam int NCH = 2;
  localparam int CLK_MHZ = 20;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int OC_MIN_US = 200;
  localparam int OC_MAX_US = 390;
  localparam int OC_CYC = OC_MIN_US * CLK_MHZ;
  localparam logic [11:0] OC_LAST = 12'(OC_CYC - 1);
  localparam int DIAG_PHASE_US = 100;
  localparam int DIAG_PHASE_CYC = DIAG_PHASE_US * CLK_MHZ;
  // -------------------------------------------------------------------
  // temperatures in degrees C
  // -------------------------------------------------------------------
  localparam int WARN_T0 = 125;
  localparam int WARN_STEP = 10;
  localparam int WARN_HYST = 10;
  localparam logic [7:0] OVERTEMP_SHUTDOWN_ON = 8'd155;
  localparam logic [7:0] OVERTEMP_SHUTDOWN_OFF = 8'd145;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] ADR_FAULT = 8'h02;
  localparam logic [7:0] ADR_SUPPLY = 8'h03;
  localparam logic [7:0] ADR_THERM = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam logic [7:0] ADR_DCDUR = 8'h09;
  localparam logic [7:0] ADR_SEL = 8'h0a;
  localparam logic [7:0] ADR_CHST = 8'h0c;
  localparam logic [7:0] ADR_DIAG0 = 8'h10;
  localparam logic [7:0] ADR_DIAG1 = 8'h11;
  localparam int THERM_LSB = 5;
  localparam int CMD_START = 0;
  localparam int CMD_TWEET = 1;
  localparam int CMD_DCSD = 2;
  localparam int CMD_FRST = 3;
  localparam int DG_REDUCED = 6;
  localparam int DG_DONE = 7;
  localparam logic [7:0] CHST_RST = 8'h00;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [7:0] DCDUR_RST = 8'h10;
  typedef enum logic [1:0] {
    SEL_CLIP = 2'b00, SEL_WARN = 2'b01, SEL_BOTH = 2'b10, SEL_TWEET = 2'b11
  } apd_sel_e;
  typedef enum logic [1:0] {
    PH_GND = 2'b00, PH_SUP = 2'b01, PH_ACROSS = 2'b10, PH_OPEN = 2'b11
  } apd_phase_e;
  typedef enum logic {DS_IDLE = 1'b0, DS_RUN = 1'b1} apd_dstate_e;
  typedef struct packed {
    logic [NCH-1:0] oc_peak;
    logic [NCH-1:0] avg_over;
    logic [NCH-1:0] dc_off;
    logic [NCH-1:0] clip_full;
  } apd_det_s;
  typedef struct packed {
    logic uv_power_stage_supply;
    logic uv_analog_supply;
    logic uv_cp;
    logic ov;
    logic load_dump;
    logic por;
  } apd_sup_s;
endpackage : apd_pkg

// ### hdl/apd_prot_ctrl.sv
`timescale 1ns/100ps
module apd_prot_ctrl #(
  parameter int DIAG_CYC = apd_pkg::DIAG_PHASE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire apd_pkg::apd_det_s det,
  input wire apd_pkg::apd_sup_s sup,
  input wire logic [7:0] die_temp,
  input wire logic pwm_tick,
  input wire logic [apd_pkg::NCH-1:0] diag_hit,
  output logic [apd_pkg::NCH-1:0] pwm_cut,
  output logic [apd_pkg::NCH-1:0] ch_float,
  output logic [apd_pkg::NCH-1:0] diag_drive,
  output apd_pkg::apd_phase_e diag_phase,
  output logic fault_n,
  output logic clip_warn_output_n,
  output logic i2c_float
);
  localparam int N = apd_pkg::NCH;
  // -------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------
  logic soft_rst;
  logic wr_cmd;
  logic start_req;
  logic frst;
  logic [7:0] chst;
  logic [1:0] sel;
  logic [7:0] dcdur;
  logic tweet_en;
  logic dcsd_en;
  logic overtemp_shutdown;
  logic overtemp_shutdown_q;
  // power-on reset and load dump wipe the setup; controller must reinit
  assign soft_rst = sup.por | sup.load_dump;
  assign wr_cmd = reg_wr && reg_addr == apd_pkg::ADR_CMD;
  assign start_req = wr_cmd && reg_wdata[apd_pkg::CMD_START];
  assign frst = wr_cmd && reg_wdata[apd_pkg::CMD_FRST];

  // channel play bits; overheating drops them so restart is explicit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      chst <= apd_pkg::CHST_RST;
    else if (soft_rst || (overtemp_shutdown && !overtemp_shutdown_q))
      chst <= apd_pkg::CHST_RST;
    else if (reg_wr && reg_addr == apd_pkg::ADR_CHST)
      chst <= reg_wdata;
  end

  // setup registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel <= apd_pkg::SEL_RST;
      dcdur <= apd_pkg::DCDUR_RST;
      tweet_en <= 1'b0;
      dcsd_en <= 1'b0;
    end
    else if (soft_rst)
    begin
      sel <= apd_pkg::SEL_RST;
      dcdur <= apd_pkg::DCDUR_RST;
      tweet_en <= 1'b0;
      dcsd_en <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == apd_pkg::ADR_SEL)
        sel <= reg_wdata[1:0];
      if (reg_wr && reg_addr == apd_pkg::ADR_DCDUR)
        dcdur <= reg_wdata;
      if (wr_cmd)
      begin
        tweet_en <= reg_wdata[apd_pkg::CMD_TWEET];
        dcsd_en <= reg_wdata[apd_pkg::CMD_DCSD];
      end
    end
  end

  // -------------------------------------------------------------------
  // thermal monitor
  // -------------------------------------------------------------------
  logic [2:0] warn;
  for (genvar g = 0; g < 3; g++)
  begin : g_warn
    localparam logic [7:0] ON = 8'(apd_pkg::WARN_T0 + g * apd_pkg::WARN_STEP);
    localparam logic [7:0] OFF = 8'(ON - apd_pkg::WARN_HYST);
    // each step sets at its threshold, clears once more than 10 below it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        warn[g] <= 1'b0;
      else if (die_temp >= ON)
        warn[g] <= 1'b1;
      else if (die_temp < OFF)
        warn[g] <= 1'b0;
    end
  end

  // shutdown band: on at 155, released at 145
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overtemp_shutdown <= 1'b0;
      overtemp_shutdown_q <= 1'b0;
    end
    else
    begin
      overtemp_shutdown_q <= overtemp_shutdown;
      if (die_temp >= apd_pkg::OVERTEMP_SHUTDOWN_ON)
        overtemp_shutdown <= 1'b1;
      else if (die_temp <= apd_pkg::OVERTEMP_SHUTDOWN_OFF)
        overtemp_shutdown <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // overcurrent and dc offset detectors, one set per channel
  // -------------------------------------------------------------------
  logic [11:0] oc_cnt [N];
  logic [7:0] dc_cnt [N];
  logic [N-1:0] oc_hit;
  logic [N-1:0] dc_hit;
  for (genvar c = 0; c < N; c++)
  begin : g_ch
    // a peak must persist 200us; shorter ones are left to the limiter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        oc_cnt[c] <= '0;
      else if (!det.oc_peak[c] || ch_float[c])
        oc_cnt[c] <= '0;
      else if (oc_cnt[c] != apd_pkg::OC_LAST)
        oc_cnt[c] <= oc_cnt[c] + 12'h0001;
    end
    assign oc_hit[c] = det.oc_peak[c] && oc_cnt[c] == apd_pkg::OC_LAST;

    // offset duration counted in switching periods
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        dc_cnt[c] <= '0;
      else if (!det.dc_off[c] || ch_float[c])
        dc_cnt[c] <= '0;
      else if (pwm_tick && dc_cnt[c] != dcdur)
        dc_cnt[c] <= dc_cnt[c] + 8'h01;
    end
    assign dc_hit[c] = det.dc_off[c] && dc_cnt[c] == dcdur;
  end

  // -------------------------------------------------------------------
  // fault record: set wins over the reset command
  // -------------------------------------------------------------------
  logic [N-1:0] flt_oc;
  logic [N-1:0] flt_dc;
  logic flt_ov;
  logic flt_ld;
  logic [2:0] uv;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flt_oc <= '0;
      flt_dc <= '0;
      flt_ov <= 1'b0;
      flt_ld <= 1'b0;
      uv <= 3'h0;
    end
    else
    begin
      flt_oc <= (frst ? '0 : flt_oc) | oc_hit;
      flt_dc <= (frst ? '0 : flt_dc) | (dc_hit & {N{dcsd_en}});
      flt_ov <= (!frst & flt_ov) | sup.ov;
      flt_ld <= (!frst & flt_ld) | sup.load_dump;
      uv <= (frst ? 3'h0 : uv) | {sup.uv_cp, sup.uv_analog_supply, sup.uv_power_stage_supply};
    end
  end

  // -------------------------------------------------------------------
  // load diagnostics
  // -------------------------------------------------------------------
  apd_pkg::apd_dstate_e ds;
  logic [15:0] dtim;
  logic reduced;
  logic [N-1:0] dmask;
  logic [3:0] dres [N];
  logic [N-1:0] ddone;
  logic phase_end;
  logic last_phase;
  assign phase_end = dtim == 16'(DIAG_CYC - 1);
  assign last_phase = reduced ? diag_phase == apd_pkg::PH_SUP
                              : diag_phase == apd_pkg::PH_OPEN;

  // started only while some output already floats
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ds <= apd_pkg::DS_IDLE;
      dtim <= 16'h0000;
      reduced <= 1'b0;
      dmask <= '0;
      diag_phase <= apd_pkg::PH_GND;
    end
    else
    begin
      unique case (ds)
        apd_pkg::DS_IDLE:
          if (start_req && |ch_float && !soft_rst)
          begin
            ds <= apd_pkg::DS_RUN;
            dmask <= ch_float; // both at once when both float
            reduced <= !(&ch_float);
            dtim <= 16'h0000;
            diag_phase <= apd_pkg::PH_GND;
          end
        apd_pkg::DS_RUN:
          if (soft_rst)
            ds <= apd_pkg::DS_IDLE;
          else if (phase_end)
          begin
            dtim <= 16'h0000;
            if (last_phase)
              ds <= apd_pkg::DS_IDLE;
            else // fixed phase order
              diag_phase <= apd_pkg::apd_phase_e'(diag_phase + 2'b01);
          end
          else
            dtim <= dtim + 16'h0001;
      endcase
    end
  end

  // per-channel results, one bit per phase
  for (genvar c = 0; c < N; c++)
  begin : g_res
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        dres[c] <= 4'h0;
        ddone[c] <= 1'b0;
      end
      else if (ds == apd_pkg::DS_IDLE && start_req && ch_float[c])
      begin
        dres[c] <= 4'h0;
        ddone[c] <= 1'b0;
      end
      else if (ds == apd_pkg::DS_RUN && phase_end && dmask[c])
      begin
        dres[c][diag_phase] <= diag_hit[c];
        ddone[c] <= last_phase;
      end
    end
  end

  // -------------------------------------------------------------------
  // outputs toward the power stages and pins
  // -------------------------------------------------------------------
  logic [1:0] tw_cnt;
  logic tw_low;
  logic clip_any;
  logic any_flt;
  assign clip_any = |(det.clip_full & ~ch_float);
  assign tw_low = tweet_en && (|det.avg_over || tw_cnt != 2'h0);
  assign any_flt = |flt_oc || |flt_dc || flt_ov || flt_ld || |uv || overtemp_shutdown;

  // a test holds its channels afloat even if play is written meanwhile;
  // faults float the channels one clock after they are recorded
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch_float <= '1;
      diag_drive <= '0;
      pwm_cut <= '0;
      fault_n <= 1'b1;
      i2c_float <= 1'b0;
    end
    else
    begin
      ch_float <= ~chst[N-1:0] | flt_oc | flt_dc
                | {N{overtemp_shutdown | flt_ov | flt_ld | |uv}}
                | (dmask & {N{ds == apd_pkg::DS_RUN}});
      diag_drive <= dmask & {N{ds == apd_pkg::DS_RUN}};
      pwm_cut <= det.avg_over & ~ch_float;
      fault_n <= !any_flt;
      i2c_float <= sup.por;
    end
  end

  // tweeter stretch: reload on current limit, two ticks to run out,
  // so every low pulse spans at least one full switching period
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tw_cnt <= 2'h0;
    else if (|det.avg_over)
      tw_cnt <= 2'h2;
    else if (pwm_tick && tw_cnt != 2'h0)
      tw_cnt <= tw_cnt - 2'h1;
  end

  // clip/warn pin source select
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clip_warn_output_n <= 1'b1;
    else
    begin
      unique case (apd_pkg::apd_sel_e'(sel))
        apd_pkg::SEL_CLIP: clip_warn_output_n <= !clip_any;
        apd_pkg::SEL_WARN: clip_warn_output_n <= !warn[0];
        apd_pkg::SEL_BOTH: clip_warn_output_n <= !(clip_any || warn[0]);
        apd_pkg::SEL_TWEET: clip_warn_output_n <= !tw_low;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // register reads, answered the cycle after the strobe
  // -------------------------------------------------------------------
  logic [7:0] rmux;
  always_comb
  begin
    rmux = 8'h00;
    unique case (reg_addr)
      apd_pkg::ADR_FAULT:
        rmux = {1'b0, flt_ld, flt_ov, overtemp_shutdown, flt_dc, flt_oc};
      apd_pkg::ADR_SUPPLY: rmux = {5'h00, uv};
      apd_pkg::ADR_THERM: rmux = {warn, 5'h00};
      apd_pkg::ADR_CMD: rmux = {5'h00, dcsd_en, tweet_en, ds};
      apd_pkg::ADR_DCDUR: rmux = dcdur;
      apd_pkg::ADR_SEL: rmux = {6'h00, sel};
      apd_pkg::ADR_CHST: rmux = chst;
      apd_pkg::ADR_DIAG0: rmux = {ddone[0], reduced, 2'h0, dres[0]};
      apd_pkg::ADR_DIAG1: rmux = {ddone[1], reduced, 2'h0, dres[1]};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rmux;
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_no_float_no_test;
    start_req && ds == apd_pkg::DS_IDLE && ch_float == '0
      |=> ds == apd_pkg::DS_IDLE;
  endproperty
  a_no_float_no_test: assert property (p_no_float_no_test)
    else $error("diagnostic started with no floating output");

  property p_full_level;
    start_req && ds == apd_pkg::DS_IDLE && &ch_float && !soft_rst
      |=> ##1 diag_drive == '1 && !reduced;
  endproperty
  a_full_level: assert property (p_full_level)
    else $error("full diagnostic did not drive both channels");

  property p_reduced_phases;
    ds == apd_pkg::DS_RUN && reduced
      |-> diag_phase inside {apd_pkg::PH_GND, apd_pkg::PH_SUP};
  endproperty
  a_reduced_phases: assert property (p_reduced_phases)
    else $error("reduced diagnostic ran a full-level phase");

  property p_limit_cut;
    det.avg_over[0] && !ch_float[0] |=> pwm_cut[0] && !flt_oc[0];
  endproperty
  a_limit_cut: assert property (p_limit_cut)
    else $error("current limit did not cut the pulse");

  property p_oc_delay;
    $rose(flt_oc[0]) |-> $past(oc_cnt[0]) == apd_pkg::OC_LAST;
  endproperty
  a_oc_delay: assert property (p_oc_delay)
    else $error("overcurrent shutdown outside its delay");

  property p_oc_fault;
    $rose(flt_oc[0]) |=> !fault_n ##1 ch_float[0];
  endproperty
  a_oc_fault: assert property (p_oc_fault)
    else $error("overcurrent did not raise fault and float");

  property p_warn_hold;
    warn[0] && die_temp >= 8'(apd_pkg::WARN_T0 - apd_pkg::WARN_HYST)
      |=> warn[0];
  endproperty
  a_warn_hold: assert property (p_warn_hold)
    else $error("thermal warning dropped above 115C");

  property p_overtemp_shutdown_float;
    overtemp_shutdown |=> ch_float == '1 && !fault_n;
  endproperty
  a_overtemp_shutdown_float: assert property (p_overtemp_shutdown_float)
    else $error("thermal shutdown left an output switching");

  property p_tweet_low;
    sel == apd_pkg::SEL_TWEET && tweet_en && |det.avg_over
      |=> !clip_warn_output_n;
  endproperty
  a_tweet_low: assert property (p_tweet_low)
    else $error("tweeter detect did not pull the pin low");
endmodule : apd_prot_ctrl

// ### dv/apd_mcu_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// system controller: byte accesses, strobe up for one clock
// ---------------------------------------------------------------
module apd_mcu_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle port from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // lines inverted after use so a late capture sees garbage
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // data taken a cycle after the strobe drops, where it holds
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd

  // playing channels go quiet before a load test
  task automatic mute_float;
    wr(apd_pkg::ADR_CHST, 8'h00);
  endtask : mute_float

  // tweeter mode first, then play and pin source
  task automatic tweet_setup(input logic [7:0] chst);
    wr(apd_pkg::ADR_CMD, 8'h02);
    wr(apd_pkg::ADR_CHST, chst);
    wr(apd_pkg::ADR_SEL, 8'h03);
  endtask : tweet_setup

  // settings were wiped by the supply event, so set select, dc duration and play again
  task automatic reinit(input logic [7:0] chst);
    wr(apd_pkg::ADR_SEL, 8'h00);
    wr(apd_pkg::ADR_DCDUR, 8'h04);
    wr(apd_pkg::ADR_CHST, chst);
  endtask : reinit
endmodule : apd_mcu_model

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  apd_pkg::apd_det_s det;
  apd_pkg::apd_sup_s sup;
  logic [7:0] die_temp;
  logic pwm_tick = 1'b0;
  logic [1:0] tick_cnt = 2'd0;
  logic [1:0] diag_hit;
  logic [1:0] pwm_cut;
  logic [1:0] ch_float;
  logic [1:0] diag_drive;
  apd_pkg::apd_phase_e diag_phase;
  logic fault_n;
  logic clip_warn_output_n;
  logic i2c_float;
  logic [7:0] pins;
  int fails = 0;
  int num_checks = 0;

  // short phases keep the load test quick
  apd_prot_ctrl #(.DIAG_CYC(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .det(det), .sup(sup),
    .die_temp(die_temp), .pwm_tick(pwm_tick), .diag_hit(diag_hit),
    .pwm_cut(pwm_cut), .ch_float(ch_float), .diag_drive(diag_drive),
    .diag_phase(diag_phase), .fault_n(fault_n),
    .clip_warn_output_n(clip_warn_output_n), .i2c_float(i2c_float));
  apd_mcu_model u_mcu (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // switching period of four clocks
  always @(negedge ref_clk)
  begin
    tick_cnt <= tick_cnt + 2'd1;
    pwm_tick <= (tick_cnt == 2'd3);
  end

  // ch0 shorted to supply; ch1 shorted to ground and open
  assign diag_hit = {diag_phase == apd_pkg::PH_OPEN
    || diag_phase == apd_pkg::PH_GND, diag_phase == apd_pkg::PH_SUP};
  // status pins packed so one compare covers them all
  assign pins = {1'b0, i2c_float, clip_warn_output_n, fault_n,
    diag_drive, ch_float};

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    if (fails == 0 && num_checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_mcu.rd(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // a used-up wait ends the run at once
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      fails++;
      $display("CHECK FAILED wait exp %0d got %0d", lim, n);
      conclude();
    end
  endtask : tmo

  // follows one load test, logging each new phase code
  task automatic diag_run(input logic [7:0] ep, input logic [7:0] es);
    int n;
    apd_pkg::apd_phase_e prev;
    logic [7:0] seq;
    n = 0;
    seq = 8'h00;
    prev = apd_pkg::PH_GND;
    while (diag_drive === 2'b00 && n < 6)
    begin
      cyc(1);
      n++;
    end
    tmo(n, 6);
    chk("diag_pins", ep, pins);
    while (diag_drive !== 2'b00 && n < 100)
    begin
      if (diag_phase !== prev)
      begin
        seq = {seq[5:0], diag_phase};
      end
      prev = diag_phase;
      cyc(1);
      n++;
    end
    tmo(n, 100);
    chk("diag_order", es, seq);
  endtask : diag_run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("rst_pins", 8'h33, pins);
    rdchk(apd_pkg::ADR_CHST, 8'h00);
    rdchk(apd_pkg::ADR_DCDUR, 8'h10);
    rdchk(apd_pkg::ADR_CMD, 8'h00);
    u_mcu.wr(apd_pkg::ADR_THERM, 8'hff);
    rdchk(apd_pkg::ADR_THERM, 8'h00);
    rdchk(8'h05, 8'h00);
    u_mcu.wr(apd_pkg::ADR_SEL, 8'h02);
    rdchk(apd_pkg::ADR_SEL, 8'h02);
  endtask : t_reset

  task automatic t_diag;
    u_mcu.mute_float();
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h01);
    diag_run(8'h3f, 8'h1b);
    rdchk(apd_pkg::ADR_DIAG0, 8'h82);
    rdchk(apd_pkg::ADR_DIAG1, 8'h89);
    u_mcu.wr(apd_pkg::ADR_CHST, 8'h01);
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h01);
    diag_run(8'h3a, 8'h01);
    rdchk(apd_pkg::ADR_DIAG0, 8'hc2);
    rdchk(apd_pkg::ADR_DIAG1, 8'hc1);
    u_mcu.wr(apd_pkg::ADR_CHST, 8'h03);
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h01);
    cyc(5);
    chk("diag_refused", 8'h30, pins);
  endtask : t_diag

  task automatic t_current;
    int n;
    det.oc_peak = 2'b01;
    n = 0;
    while (ch_float[0] !== 1'b1 && n < 8000)
    begin
      cyc(1);
      n++;
    end
    tmo(n, 8000);
    chk("oc_time", 8'h01, {7'h0, n >= 3999 && n <= 7800});
    cyc(2);
    chk("oc_pins", 8'h21, pins);
    rdchk(apd_pkg::ADR_FAULT, 8'h01);
    det.oc_peak = 2'b00;
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h08);
    cyc(3);
    chk("oc_restart", 8'h30, pins);
    det.avg_over = 2'b10;
    cyc(2);
    chk("cut", 8'h02, {6'h0, pwm_cut});
    cyc(20);
    chk("cut_pins", 8'h30, pins);
    det.avg_over = 2'b00;
  endtask : t_current

  task automatic t_dc;
    u_mcu.wr(apd_pkg::ADR_DCDUR, 8'h04);
    det.dc_off = 2'b10;
    cyc(40);
    chk("dc_off_pins", 8'h30, pins);
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h04);
    cyc(40);
    chk("dc_on_pins", 8'h22, pins);
    rdchk(apd_pkg::ADR_FAULT, 8'h08);
    det.dc_off = 2'b00;
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h0c);
    cyc(3);
    chk("dc_clear", 8'h30, pins);
  endtask : t_dc

  task automatic t_therm;
    logic [7:0] tp [9] = '{124, 125, 124, 135, 145, 135, 134, 115, 114};
    logic [7:0] ex [9] = '{0, 'h20, 'h20, 'h60, 'he0, 'he0, 'h60, 'h20, 0};
    u_mcu.wr(apd_pkg::ADR_SEL, 8'h01);
    for (int i = 0; i < 9; i++)
    begin
      die_temp = tp[i];
      cyc(3);
      rdchk(apd_pkg::ADR_THERM, ex[i]);
      chk("warn_pin", (ex[i] == 0) ? 8'h30 : 8'h10, pins);
    end
    die_temp = 8'd155;
    cyc(3);
    chk("overtemp_shutdown_pins", 8'h03, pins);
    rdchk(apd_pkg::ADR_FAULT, 8'h10);
    die_temp = 8'd146;
    cyc(3);
    chk("overtemp_shutdown_hold", 8'h03, pins);
    die_temp = 8'd145;
    cyc(3);
    chk("overtemp_shutdown_free", 8'h13, pins);
    u_mcu.wr(apd_pkg::ADR_CHST, 8'h03);
    cyc(3);
    chk("overtemp_shutdown_play", 8'h10, pins);
    // warning alone, then clip alone, through the first three sources
    for (int s = 0; s < 3; s++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        det.clip_full = c ? 2'b01 : 2'b00;
        die_temp = c ? 8'd25 : 8'd130;
        u_mcu.wr(apd_pkg::ADR_SEL, 8'(s));
        cyc(3);
        chk("sel_pin", {7'h0, c ? s == 1 : s == 0},
          {7'h0, clip_warn_output_n});
      end
    end
    det.clip_full = 2'b00;
    die_temp = 8'd25;
  endtask : t_therm

  task automatic t_tweet;
    u_mcu.tweet_setup(8'h01);
    cyc(3);
    chk("tw_idle", 8'h32, pins);
    det.avg_over = 2'b01;
    cyc(2);
    chk("tw_low", 8'h12, pins);
    det.avg_over = 2'b00;
    cyc(1);
    chk("tw_min", 8'h12, pins);
    cyc(12);
    chk("tw_high", 8'h32, pins);
    u_mcu.wr(apd_pkg::ADR_SEL, 8'h00);
  endtask : t_tweet

  task automatic t_supply;
    for (int i = 0; i < 3; i++)
    begin
      sup = 6'h20 >> i;
      cyc(2);
      chk("uv_fault", 8'h00, {7'h0, fault_n});
      rdchk(apd_pkg::ADR_SUPPLY, 8'h01 << i);
      sup = '0;
      u_mcu.wr(apd_pkg::ADR_CMD, 8'h08);
      cyc(2);
      chk("uv_clear", 8'h01, {7'h0, fault_n});
    end
    sup.ov = 1'b1;
    cyc(2);
    chk("ov_fault", 8'h00, {7'h0, fault_n});
    rdchk(apd_pkg::ADR_FAULT, 8'h20);
    sup = '0;
    sup.load_dump = 1'b1;
    cyc(3);
    chk("ld_pins", 8'h23, pins);
    rdchk(apd_pkg::ADR_FAULT, 8'h60);
    sup = '0;
    u_mcu.wr(apd_pkg::ADR_CMD, 8'h08);
    u_mcu.reinit(8'h03);
    cyc(3);
    chk("ld_restart", 8'h30, pins);
    sup.por = 1'b1;
    cyc(3);
    chk("por_float", 8'h01, {7'h0, i2c_float});
    sup = '0;
    cyc(3);
    chk("por_back", 8'h00, {7'h0, i2c_float});
    rdchk(apd_pkg::ADR_DCDUR, 8'h10);
    u_mcu.reinit(8'h03);
  endtask : t_supply

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    det = '0;
    sup = '0;
    die_temp = 8'd25;
    cyc(2);
    rst_n = 1'b1;
    t_reset();
    t_diag();
    t_current();
    t_dc();
    t_therm();
    t_tweet();
    t_supply();
    conclude();
  end
endmodule : tb
